// ### calc_if.sv
// Request and answer bundle between the classifier and an arithmetic unit.
// Start is a one-cycle pulse; done is a one-cycle pulse with q valid.
`timescale 1ns/1ns
`default_nettype none
interface calc_if #(
  parameter int AW = 26,
  parameter int QW = 24
) ();
  logic          start;
  logic [AW-1:0] a;
  logic [AW-1:0] b;
  logic          done;
  logic [QW-1:0] q;

  modport client (output start, output a, output b,
                  input done, input q);
  modport server (input start, input a, input b,
                  output done, output q);
endinterface
`default_nettype wire

// ### front_end_model.sv
// Front-end model: hands four-channel samples to the classifier.
// Assumes send() is called just after a falling edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module front_end_model (
  // Clock
  input  wire logic             clk_sys,
  // Samples
  output var  logic             sample_valid,
  output var  logic             sample_slot,
  output var  logic [3:0][15:0] sample_ch
);
  logic clocks_trimmed;
  logic mode_normal;
  initial begin
    sample_valid = 1'b0;
    sample_slot = 1'b0;
    sample_ch = '0;
    clocks_trimmed = 1'b1;
    mode_normal = 1'b1;
  end
  // One queue word per interrupt; nothing before set-up is done
  task automatic send(input logic slot, input logic [15:0] l, r, t, b);
    if (clocks_trimmed && mode_normal) begin
      sample_valid = 1'b1;
      sample_slot = slot;
      sample_ch = {b, t, r, l};
      @(negedge clk_sys);
      sample_valid = 1'b0;
      // Stale word inverted so it cannot pass for fresh data
      sample_ch = ~sample_ch;
      sample_slot = ~slot;
    end
  endtask
endmodule
`default_nettype wire

// ### gesture_asserts.sv
// Checker for the gesture classifier top module.
// Assumes one clock domain and bind to the top module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "gesture_map.svh"
module gesture_asserts (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  // Samples and offsets
  input wire logic                  sample_valid,
  input wire logic                  off_wr,
  input wire logic                  off_slot,
  input wire logic [1:0]            off_ch,
  input wire logic [15:0]           off_wdata,
  input wire logic [15:0]           off_rdata,
  // Result
  input wire logic                  gesture_valid,
  input wire gesture_pkg::gesture_e gesture_code,
  input wire logic [`POS_W-1:0]     gesture_slope,
  input wire logic [`ROOT_W-1:0]    gesture_dist,
  input wire logic                  busy
);
  // Saturation keeps the negation from overflowing
  logic [`POS_W-1:0] slope_mag;
  logic              steep;
  logic              shallow;
  always_comb slope_mag = gesture_slope[`POS_W-1] ? -gesture_slope
                                                  : gesture_slope;
  assign steep = gesture_code inside {gesture_pkg::G_UP, gesture_pkg::G_DOWN};
  assign shallow = gesture_code inside {gesture_pkg::G_LEFT,
                                        gesture_pkg::G_RIGHT};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence wr_held;
    off_wr ##1 (!off_wr && $stable(off_slot) && $stable(off_ch));
  endsequence
  reset_rdata_a: assert property ($rose(rst_b) |-> off_rdata == 16'h2000)
    else $error("Offset readback wrong after reset");
  rdata_follow_a: assert property (wr_held |=> off_rdata == $past(off_wdata, 2))
    else $error("Offset readback does not follow write");
  busy_cause_a: assert property ($rose(busy) |-> $past(sample_valid))
    else $error("Busy without a sample");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:220] !busy)
    else $error("Busy too long");
  valid_pulse_a: assert property (gesture_valid |=> !gesture_valid)
    else $error("Result strobe longer than one cycle");
  valid_idle_a: assert property (gesture_valid |-> !busy && $past(busy))
    else $error("Result strobe not at end of computing");
  result_hold_a: assert property (!gesture_valid |-> $stable(gesture_code)
    && $stable(gesture_dist) && $stable(gesture_slope))
    else $error("Result changed without strobe");
  code_legal_a: assert property (gesture_valid |-> gesture_code != 3'h0
    && gesture_code <= 3'h5)
    else $error("Illegal gesture code");
  steep_slope_a: assert property (gesture_valid && steep
    |-> slope_mag >= 24'h100000)
    else $error("Vertical swipe with shallow slope");
  shallow_slope_a: assert property (gesture_valid && shallow
    |-> slope_mag < 24'h100000)
    else $error("Horizontal swipe with steep slope");
endmodule
bind gesture_classifier gesture_asserts u_asserts (.clk_sys(clk_sys),
  .rst_b(rst_b), .sample_valid(sample_valid), .off_wr(off_wr),
  .off_slot(off_slot), .off_ch(off_ch), .off_wdata(off_wdata),
  .off_rdata(off_rdata), .gesture_valid(gesture_valid),
  .gesture_code(gesture_code), .gesture_slope(gesture_slope),
  .gesture_dist(gesture_dist), .busy(busy));
`default_nettype wire

// ### gesture_classifier.sv
// Gesture classifier: offset correction, start and end detection,
// angular positions, slope, distance and gesture decision.
// Assumes samples arrive on clk_sys from logic that drains the front end.
`timescale 1ns/1ns
`default_nettype none
`include "gesture_map.svh"
// Function
// - Subtract per-channel offsets, one set per time slot.
// - All offsets leave reset at 2000 hex.
// - Intensity is the sum of four corrected channels.
// - Start when intensity exceeds the threshold, default 1000.
// - At start take x and y position ratios.
// - Skip end testing for a set sample count, default five.
// - Then end when intensity drops below the same threshold.
// - At end take x and y positions again.
// - Slope is dy over dx plus one millionth.
// - Distance is the root of dx squared plus dy squared.
// - Click when distance below threshold or slope magnitude is one.
// - Steep slope: up if y start exceeds y end, else down.
// - Shallow slope: left if x start exceeds x end, else right.
module gesture_classifier (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // Samples from the front end
  input  wire logic                  sample_valid,
  input  wire logic                  sample_slot,
  input  wire logic [3:0][15:0]      sample_ch,
  // Offset access
  input  wire logic                  off_wr,
  input  wire logic                  off_slot,
  input  wire logic [1:0]            off_ch,
  input  wire logic [15:0]           off_wdata,
  output var  logic [15:0]           off_rdata,
  // Detection settings
  input  wire logic                  cfg_wr,
  input  wire logic [15:0]           cfg_thresh,
  input  wire logic [7:0]            cfg_min,
  input  wire logic [`ROOT_W-1:0]    cfg_dist,
  input  wire logic                  track_slot,
  // Result
  output var  logic                  gesture_valid,
  output var  gesture_pkg::gesture_e gesture_code,
  output var  logic [`POS_W-1:0]     gesture_slope,
  output var  logic [`ROOT_W-1:0]    gesture_dist,
  output var  logic                  busy
);
  // Settings
  logic [1:0][3:0][15:0]     off,       next_off;
  logic [15:0]               next_off_rdata;
  logic [15:0]               thresh,    next_thresh;
  logic [7:0]                min_cnt,   next_min_cnt;
  logic [`ROOT_W-1:0]        dist_thr,  next_dist_thr;

  // Sample path
  logic [3:0][16:0]          cor;
  logic signed [18:0]        intensity;
  logic signed [18:0]        thr_s;
  logic                      accept;

  // Gesture state
  gesture_pkg::state_e       state,     next_state;
  logic                      issued,    next_issued;
  logic                      at_end,    next_at_end;
  logic [7:0]                cnt,       next_cnt;
  logic [3:0][16:0]          lat,       next_lat;
  logic signed [`POS_W-1:0]  xs,        next_xs;
  logic signed [`POS_W-1:0]  ys,        next_ys;
  logic signed [`POS_W-1:0]  xe,        next_xe;
  logic signed [`POS_W-1:0]  ye,        next_ye;
  logic [`POS_W-1:0]         m_val,     next_m_val;
  logic [`ROOT_W-1:0]        d_val,     next_d_val;
  logic [`POS_W-1:0]         next_slope;
  logic [`ROOT_W-1:0]        next_dist;
  gesture_pkg::gesture_e     next_code;
  logic                      next_valid;
  logic                      next_busy;

  // Arithmetic
  logic signed [17:0]        pa;
  logic signed [17:0]        pb;
  logic signed [`POS_W:0]    dx;
  logic signed [`POS_W:0]    dy;
  logic signed [`POS_W+1:0]  den;
  logic [`POS_W+1:0]         ady;
  logic [`POS_W+1:0]         aden;
  logic [1:0]                ia;

  calc_if #(.AW(`DIV_W),  .QW(`POS_W))  div_bus ();
  calc_if #(.AW(`SQRT_W), .QW(`ROOT_W)) sqrt_bus ();

  ratio_div u_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (div_bus.server)
  );

  int_sqrt u_sqrt (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (sqrt_bus.server)
  );

  // Settings group
  always_comb begin
    next_off       = off;
    next_thresh    = thresh;
    next_min_cnt   = min_cnt;
    next_dist_thr  = dist_thr;
    next_off_rdata = off[off_slot][off_ch];
    if (off_wr) begin
      next_off[off_slot][off_ch] = off_wdata;
    end
    if (cfg_wr) begin
      next_thresh   = cfg_thresh;
      next_min_cnt  = cfg_min;
      next_dist_thr = cfg_dist;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      off       <= {8{`OFFSET_RESET}};
      off_rdata <= `OFFSET_RESET;
      thresh    <= `THRESH_RESET;
      min_cnt   <= `MIN_SAMPLES_RESET;
      dist_thr  <= `DIST_RESET;
    end else begin
      off       <= next_off;
      off_rdata <= next_off_rdata;
      thresh    <= next_thresh;
      min_cnt   <= next_min_cnt;
      dist_thr  <= next_dist_thr;
    end
  end

  // Offset-corrected channels and intensity
  always_comb begin
    intensity = '0;
    for (int i = 0; i < 4; i++) begin
      cor[i] = {1'b0, sample_ch[i]}
             - {1'b0, off[sample_slot][i]};
      intensity = intensity + 19'($signed(cor[i]));
    end
  end

  assign thr_s  = $signed({3'h0, thresh});
  // Only the tracked slot feeds detection; the other sensor would mix in
  assign accept = sample_valid && (sample_slot == track_slot);

  // Operands of the arithmetic units
  always_comb begin
    ia = (state == gesture_pkg::ST_POS_Y) ? 2'h2 : 2'h0;
    pa = 18'($signed(lat[ia])) - 18'($signed(lat[ia + 2'h1]));
    pb = 18'($signed(lat[ia])) + 18'($signed(lat[ia + 2'h1]));
    dx  = (`POS_W+1)'(xs) - (`POS_W+1)'(xe);
    dy  = (`POS_W+1)'(ys) - (`POS_W+1)'(ye);
    den = (`POS_W+2)'(dx) + (`POS_W+2)'(1);
    ady  = dy[`POS_W] ? (`POS_W+2)'(-dy) : (`POS_W+2)'(dy);
    aden = den[`POS_W+1] ? -den : den;
    div_bus.start = !issued && (state == gesture_pkg::ST_POS_X
                              || state == gesture_pkg::ST_POS_Y
                              || state == gesture_pkg::ST_SLOPE);
    if (state == gesture_pkg::ST_SLOPE) begin
      div_bus.a = (`DIV_W)'(dy);
      div_bus.b = den;
    end else begin
      div_bus.a = (`DIV_W)'(pa);
      div_bus.b = (`DIV_W)'(pb);
    end
    sqrt_bus.start = !issued && (state == gesture_pkg::ST_DIST);
    sqrt_bus.a = (`SQRT_W)'(dx * dx) + (`SQRT_W)'(dy * dy);
    sqrt_bus.b = '0;
  end

  // Gesture sequence
  always_comb begin
    next_state  = state;
    next_issued = issued;
    next_at_end = at_end;
    next_cnt    = cnt;
    next_lat    = lat;
    next_xs     = xs;
    next_ys     = ys;
    next_xe     = xe;
    next_ye     = ye;
    next_slope  = gesture_slope;
    next_dist   = gesture_dist;
    next_code   = gesture_code;
    next_valid  = 1'b0;
    next_m_val  = m_val;
    next_d_val  = d_val;
    unique case (state)
      gesture_pkg::ST_IDLE: begin
        if (accept && intensity > thr_s) begin
          next_lat    = cor;
          next_at_end = 1'b0;
          next_cnt    = '0;
          next_issued = 1'b0;
          next_state  = gesture_pkg::ST_POS_X;
        end
      end
      gesture_pkg::ST_POS_X: begin
        if (div_bus.start) begin
          next_issued = 1'b1;
        end
        if (div_bus.done) begin
          next_issued = 1'b0;
          if (at_end) begin
            next_xe = div_bus.q;
          end else begin
            next_xs = div_bus.q;
          end
          next_state = gesture_pkg::ST_POS_Y;
        end
      end
      gesture_pkg::ST_POS_Y: begin
        if (div_bus.start) begin
          next_issued = 1'b1;
        end
        if (div_bus.done) begin
          next_issued = 1'b0;
          if (at_end) begin
            next_ye    = div_bus.q;
            next_state = gesture_pkg::ST_SLOPE;
          end else begin
            next_ys    = div_bus.q;
            next_state = gesture_pkg::ST_TRACK;
          end
        end
      end
      gesture_pkg::ST_TRACK: begin
        if (accept) begin
          if (cnt >= min_cnt) begin
            if (intensity < thr_s) begin
              next_lat    = cor;
              next_at_end = 1'b1;
              next_issued = 1'b0;
              next_state  = gesture_pkg::ST_POS_X;
            end
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
      end
      gesture_pkg::ST_SLOPE: begin
        if (div_bus.start) begin
          next_issued = 1'b1;
        end
        if (div_bus.done) begin
          next_issued = 1'b0;
          next_m_val  = div_bus.q;
          next_state  = gesture_pkg::ST_DIST;
        end
      end
      gesture_pkg::ST_DIST: begin
        if (sqrt_bus.start) begin
          next_issued = 1'b1;
        end
        if (sqrt_bus.done) begin
          next_issued = 1'b0;
          next_d_val  = sqrt_bus.q;
          next_state  = gesture_pkg::ST_CLASS;
        end
      end
      gesture_pkg::ST_CLASS: begin
        // Magnitudes compared across the divide, so |m| = 1 is exact
        if (d_val < dist_thr || ady == aden) begin
          next_code = gesture_pkg::G_CLICK;
        end else if (ady > aden) begin
          next_code = (ys > ye) ? gesture_pkg::G_UP
                                : gesture_pkg::G_DOWN;
        end else begin
          next_code = (xs > xe) ? gesture_pkg::G_LEFT
                                : gesture_pkg::G_RIGHT;
        end
        next_valid = 1'b1;
        // Results change only with the strobe
        next_slope = m_val;
        next_dist  = d_val;
        next_state = gesture_pkg::ST_IDLE;
      end
      default: begin
        next_state = gesture_pkg::ST_IDLE;
      end
    endcase
    next_busy = next_state != gesture_pkg::ST_IDLE
             && next_state != gesture_pkg::ST_TRACK;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state         <= gesture_pkg::ST_IDLE;
      issued        <= 1'b0;
      at_end        <= 1'b0;
      cnt           <= '0;
      lat           <= '0;
      xs            <= '0;
      ys            <= '0;
      xe            <= '0;
      ye            <= '0;
      m_val         <= '0;
      d_val         <= '0;
      gesture_slope <= '0;
      gesture_dist  <= '0;
      gesture_code  <= gesture_pkg::G_NONE;
      gesture_valid <= 1'b0;
      busy          <= 1'b0;
    end else begin
      state         <= next_state;
      issued        <= next_issued;
      at_end        <= next_at_end;
      cnt           <= next_cnt;
      lat           <= next_lat;
      xs            <= next_xs;
      ys            <= next_ys;
      xe            <= next_xe;
      ye            <= next_ye;
      m_val         <= next_m_val;
      d_val         <= next_d_val;
      gesture_slope <= next_slope;
      gesture_dist  <= next_dist;
      gesture_code  <= next_code;
      gesture_valid <= next_valid;
      busy          <= next_busy;
    end
  end
endmodule
`default_nettype wire

// ### gesture_map.svh
// Constants of the gesture classifier: reset values, widths, step counts.
// Included by the classifier, the arithmetic units, the checker and the bench; holds definitions only.
`ifndef GESTURE_MAP_SVH
`define GESTURE_MAP_SVH

// Reset values of the settings
`define OFFSET_RESET      16'h2000
`define THRESH_RESET      16'h03e8
`define MIN_SAMPLES_RESET 8'h05
`define DIST_RESET        25'h0040000

// Fixed-point layout, Q20 fractions
`define FRAC_BITS 20
`define POS_W     24
`define DIV_W     26
`define SQRT_W    50
`define ROOT_W    25

// Iteration counts of the arithmetic units
`define DIV_STEPS  6'h2e
`define SQRT_STEPS 5'h19

`endif

// ### gesture_pkg.sv
// Types shared by the gesture classifier modules.
// No dependencies.
package gesture_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_POS_X = 7'h02,
    ST_POS_Y = 7'h04,
    ST_TRACK = 7'h08,
    ST_SLOPE = 7'h10,
    ST_DIST  = 7'h20,
    ST_CLASS = 7'h40
  } state_e;

  typedef enum logic [2:0] {
    G_NONE  = 3'h0,
    G_CLICK = 3'h1,
    G_UP    = 3'h2,
    G_DOWN  = 3'h3,
    G_LEFT  = 3'h4,
    G_RIGHT = 3'h5
  } gesture_e;

endpackage

// ### int_sqrt.sv
// Integer square root, two radicand bits per clock.
// The b operand of the bundle is not used here.
`timescale 1ns/1ns
`default_nettype none
`include "gesture_map.svh"
module int_sqrt (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Operation
  calc_if.server    bus
);
  logic                 run,  next_run;
  logic [4:0]           cnt,  next_cnt;
  logic [`SQRT_W-1:0]   rad,  next_rad;
  logic [`ROOT_W:0]     rem,  next_rem;
  logic [`ROOT_W-1:0]   root, next_root;
  logic                 done, next_done;
  logic [`ROOT_W-1:0]   q,    next_q;
  logic [`ROOT_W+2:0]   t;
  logic [`ROOT_W+2:0]   sub;
  logic                 ge;

  always_comb begin
    next_run  = run;
    next_cnt  = cnt;
    next_rad  = rad;
    next_rem  = rem;
    next_root = root;
    next_done = 1'b0;
    next_q    = q;
    t   = {rem, rad[`SQRT_W-1 -: 2]};
    sub = {1'b0, root, 2'b01};
    ge  = t >= sub;
    if (!run && bus.start) begin
      next_run  = 1'b1;
      next_cnt  = '0;
      next_rad  = bus.a;
      next_rem  = '0;
      next_root = '0;
    end else if (run) begin
      next_rem  = ge ? (`ROOT_W+1)'(t - sub) : (`ROOT_W+1)'(t);
      next_root = {root[`ROOT_W-2:0], ge};
      next_rad  = {rad[`SQRT_W-3:0], 2'b00};
      next_cnt  = cnt + 5'h01;
      if (cnt == `SQRT_STEPS - 5'h01) begin
        next_run  = 1'b0;
        next_done = 1'b1;
        next_q    = {root[`ROOT_W-2:0], ge};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run  <= 1'b0;
      cnt  <= '0;
      rad  <= '0;
      rem  <= '0;
      root <= '0;
      done <= 1'b0;
      q    <= '0;
    end else begin
      run  <= next_run;
      cnt  <= next_cnt;
      rad  <= next_rad;
      rem  <= next_rem;
      root <= next_root;
      done <= next_done;
      q    <= next_q;
    end
  end

  assign bus.done = done;
  assign bus.q    = q;
endmodule
`default_nettype wire

// ### ratio_div.sv
// Signed fixed-point divider: q = a * 2^FRAC / b, saturated to QW bits.
// One quotient bit per clock; a start while busy is ignored.
`timescale 1ns/1ns
`default_nettype none
`include "gesture_map.svh"
module ratio_div (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Operation
  calc_if.server    bus
);
  localparam int N = `DIV_W + `FRAC_BITS;
  localparam int QW = `POS_W;

  logic                run,  next_run;
  logic [5:0]          cnt,  next_cnt;
  logic [N-1:0]        dvd,  next_dvd;
  logic [N-1:0]        quo,  next_quo;
  logic [`DIV_W:0]     rem,  next_rem;
  logic [`DIV_W-1:0]   dvs,  next_dvs;
  logic                neg,  next_neg;
  logic                zero, next_zero;
  logic                done, next_done;
  logic [QW-1:0]       q,    next_q;
  logic [`DIV_W+1:0]   t;
  logic                ge;
  logic [N-1:0]        fin;
  logic [QW-1:0]       mag;

  always_comb begin
    next_run  = run;
    next_cnt  = cnt;
    next_dvd  = dvd;
    next_quo  = quo;
    next_rem  = rem;
    next_dvs  = dvs;
    next_neg  = neg;
    next_zero = zero;
    next_done = 1'b0;
    next_q    = q;
    t   = {rem, dvd[N-1]};
    ge  = t >= {2'h0, dvs};
    fin = {quo[N-2:0], ge};
    // Saturate rather than wrap on steep slopes
    mag = (|fin[N-1:QW-1]) ? {1'b0, {(QW-1){1'b1}}} : fin[QW-1:0];
    if (!run && bus.start) begin
      next_run  = 1'b1;
      next_cnt  = '0;
      next_dvd  = {(bus.a[`DIV_W-1] ? -bus.a : bus.a),
                   {`FRAC_BITS{1'b0}}};
      next_dvs  = bus.b[`DIV_W-1] ? -bus.b : bus.b;
      next_neg  = bus.a[`DIV_W-1] ^ bus.b[`DIV_W-1];
      next_zero = bus.b == '0;
      next_rem  = '0;
      next_quo  = '0;
    end else if (run) begin
      next_rem = ge ? (`DIV_W+1)'(t - {2'h0, dvs})
                    : (`DIV_W+1)'(t);
      next_dvd = {dvd[N-2:0], 1'b0};
      next_quo = fin;
      next_cnt = cnt + 6'h01;
      if (cnt == `DIV_STEPS - 6'h01) begin
        next_run  = 1'b0;
        next_done = 1'b1;
        next_q    = zero ? '0 : (neg ? -mag : mag);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run  <= 1'b0;
      cnt  <= '0;
      dvd  <= '0;
      quo  <= '0;
      rem  <= '0;
      dvs  <= '0;
      neg  <= 1'b0;
      zero <= 1'b0;
      done <= 1'b0;
      q    <= '0;
    end else begin
      run  <= next_run;
      cnt  <= next_cnt;
      dvd  <= next_dvd;
      quo  <= next_quo;
      rem  <= next_rem;
      dvs  <= next_dvs;
      neg  <= next_neg;
      zero <= next_zero;
      done <= next_done;
      q    <= next_q;
    end
  end

  assign bus.done = done;
  assign bus.q    = q;
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the gesture classifier.
// Assumes the front-end model supplies samples; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
`include "gesture_map.svh"
module testbench;
  logic                  clk_sys;
  logic                  rst_b;
  logic                  sample_valid;
  logic                  sample_slot;
  logic [3:0][15:0]      sample_ch;
  logic                  off_wr;
  logic                  off_slot;
  logic [1:0]            off_ch;
  logic [15:0]           off_wdata;
  logic [15:0]           off_rdata;
  logic                  cfg_wr;
  logic [15:0]           cfg_thresh;
  logic [7:0]            cfg_min;
  logic [`ROOT_W-1:0]    cfg_dist;
  logic                  track_slot;
  logic                  gesture_valid;
  gesture_pkg::gesture_e gesture_code;
  logic [`POS_W-1:0]     gesture_slope;
  logic [`ROOT_W-1:0]    gesture_dist;
  logic                  busy;
  int                    fail_count;
  int                    n_checks;
  int                    cycles;

  front_end_model u_fe (.clk_sys(clk_sys), .sample_valid(sample_valid),
    .sample_slot(sample_slot), .sample_ch(sample_ch));
  gesture_classifier u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .sample_valid(sample_valid), .sample_slot(sample_slot),
    .sample_ch(sample_ch), .off_wr(off_wr), .off_slot(off_slot),
    .off_ch(off_ch), .off_wdata(off_wdata), .off_rdata(off_rdata),
    .cfg_wr(cfg_wr), .cfg_thresh(cfg_thresh), .cfg_min(cfg_min),
    .cfg_dist(cfg_dist), .track_slot(track_slot),
    .gesture_valid(gesture_valid), .gesture_code(gesture_code),
    .gesture_slope(gesture_slope), .gesture_dist(gesture_dist),
    .busy(busy));

  always #20 clk_sys = ~clk_sys;
  // Six gestures need some 1800 cycles; generous ceiling
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_code(input gesture_pkg::gesture_e got,
                            input gesture_pkg::gesture_e exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_off(input logic s, input logic [1:0] c,
                        input logic [15:0] d);
    @(negedge clk_sys);
    off_wr = 1'b1;
    off_slot = s;
    off_ch = c;
    off_wdata = d;
    @(negedge clk_sys);
    off_wr = 1'b0;
  endtask
  task automatic rd_off(input logic s, input logic [1:0] c,
                        output logic [15:0] d);
    @(negedge clk_sys);
    off_slot = s;
    off_ch = c;
    @(negedge clk_sys);
    d = off_rdata;
  endtask
  task automatic set_cfg(input logic [15:0] th, input logic [7:0] mn = 8'h05,
                         input logic [`ROOT_W-1:0] dm = 25'h0040000);
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_thresh = th;
    cfg_min = mn;
    cfg_dist = dm;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask
  task automatic feed(input logic s, input int v[4], input int base);
    @(negedge clk_sys);
    u_fe.send(s, 16'(v[0] + base), 16'(v[1] + base), 16'(v[2] + base),
              16'(v[3] + base));
  endtask
  function automatic gesture_pkg::gesture_e classify(input int s[4], e[4]);
    real xs, ys, xe, ye, m, d;
    xs = real'(s[0] - s[1]) / real'(s[0] + s[1]);
    ys = real'(s[2] - s[3]) / real'(s[2] + s[3]);
    xe = real'(e[0] - e[1]) / real'(e[0] + e[1]);
    ye = real'(e[2] - e[3]) / real'(e[2] + e[3]);
    m = (ys - ye) / (xs - xe + 1.0e-6);
    d = $sqrt((xs - xe) * (xs - xe) + (ys - ye) * (ys - ye));
    if (d < real'(cfg_dist) / 1048576.0 || m == 1.0 || m == -1.0)
      return gesture_pkg::G_CLICK;
    if (m > 1.0 || m < -1.0)
      return (ys > ye) ? gesture_pkg::G_UP : gesture_pkg::G_DOWN;
    return (xs > xe) ? gesture_pkg::G_LEFT : gesture_pkg::G_RIGHT;
  endfunction
  task automatic gesture(input logic s, input int base, input int a[4],
                         input int e[4]);
    int n;
    int mid[4] = '{250, 250, 250, 250};
    track_slot = s;
    feed(s, a, base);
    check_val(busy, 1);
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    for (int i = 0; i < cfg_min; i++) begin
      feed(s, e, base);
      check_val(busy, 0);
    end
    feed(s, mid, base);
    check_val(busy, 0);
    feed(s, e, base);
    check_val(busy, 1);
    n = 0;
    while (gesture_valid !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check_val(n >= 150 && n <= 220, 1);
    check_code(gesture_code, classify(a, e));
    check_val(busy, 0);
    @(negedge clk_sys);
    check_val(gesture_valid, 0);
  endtask

  initial begin
    logic [15:0] d;
    clk_sys = 1'b0;
    rst_b = 1'b0;
    off_wr = 1'b0;
    off_slot = 1'b0;
    off_ch = 2'h0;
    off_wdata = 16'h0000;
    cfg_wr = 1'b0;
    cfg_thresh = 16'h03e8;
    cfg_min = 8'h05;
    cfg_dist = 25'h0040000;
    track_slot = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd_off(k[2], k[1:0], d);
      check_val(d, 16'h2000);
    end
    // Idle code e000 hex per channel brings slot A to zero
    for (int k = 0; k < 4; k++)
      wr_off(1'b0, k[1:0], 16'h2000 + 16'he000);
    for (int k = 0; k < 8; k++) begin
      rd_off(k[2], k[1:0], d);
      check_val(d, k[2] ? 16'h2000 : 16'h0000);
    end
    set_cfg(16'h07d0);
    feed(1'b0, '{400, 400, 400, 300}, 0);
    check_val(busy, 0);
    set_cfg(16'h03e8);
    feed(1'b0, '{250, 250, 250, 250}, 0);
    check_val(busy, 0);
    feed(1'b1, '{900, 900, 900, 900}, 'h2000);
    check_val(busy, 0);
    gesture(1'b0, 0, '{250, 750, 500, 500}, '{300, 100, 200, 200});
    check_val(gesture_dist, 25'h0100000);
    check_val(gesture_slope, 24'h000000);
    gesture(1'b1, 'h2000, '{750, 250, 500, 500}, '{100, 300, 200, 200});
    gesture(1'b0, 0, '{500, 500, 750, 250}, '{200, 200, 100, 300});
    check_val(gesture_slope, 24'h7fffff);
    gesture(1'b0, 0, '{500, 500, 250, 750}, '{200, 200, 300, 100});
    gesture(1'b0, 0, '{600, 400, 600, 400}, '{240, 160, 240, 160});
    // Short skip count; the wide click radius turns a swipe into a click
    set_cfg(16'h03e8, 8'h02, 25'h0200000);
    gesture(1'b0, 0, '{250, 750, 500, 500}, '{300, 100, 200, 200});
    give_verdict();
  end
endmodule
`default_nettype wire
